// File: pes_pkg.sv
/*
  Package of the precise exception sequencer: register offsets, field
  positions, reset values, vector offsets and exception classes.
  Assumes a 32-bit AXI4-Lite register bus and a 100 MHz core clock.
*/
package pes_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;      // Control / loose inputs
  localparam logic [7:0] ADDR_MSTATE = 8'h04;    // Machine state
  localparam logic [7:0] ADDR_SAVE_PC = 8'h08;   // Saved restart address
  localparam logic [7:0] ADDR_SAVE_MS = 8'h0c;   // Saved machine state
  localparam logic [7:0] ADDR_CAUSE = 8'h10;     // Finer cause
  localparam logic [7:0] ADDR_STATUS = 8'h14;    // Sticky event status
  localparam logic [7:0] ADDR_MASK = 8'h18;      // Interrupt mask
  localparam logic [7:0] ADDR_VECTOR = 8'h1c;    // Last vector taken
  localparam logic [7:0] ADDR_RESUME = 8'h20;    // Handler resume address
  localparam logic [7:0] ADDR_COND_EN = 8'h24;   // Condition enables
  // Machine state field positions
  localparam int MS_RECOV = 0;                   // Recoverable flag
  localparam int MS_USER = 14;                   // Problem (user) mode
  localparam int MS_EXT_EN = 15;                 // External irq enable
  localparam logic [31:0] MS_RESET = 32'h00000000;
  // Control register fields
  localparam int CTRL_RETURN = 0;                // Return from handler
  localparam int CTRL_FP_IMPRECISE = 1;          // FP mode select (ignored)
  // Vector offsets
  localparam logic [31:0] VEC_RESERVED = 32'h00000000;
  localparam logic [31:0] VEC_RESET = 32'h00000100;
  localparam logic [31:0] VEC_MCHECK = 32'h00000200;
  localparam logic [31:0] VEC_EXT = 32'h00000500;
  localparam logic [31:0] VEC_DEC = 32'h00000900;
  localparam logic [31:0] VEC_SYS_MGMT = 32'h00001400;
  localparam logic [31:0] VEC_PROGRAM = 32'h00000700;
  localparam logic [31:0] VEC_SYSCALL = 32'h00000c00;
  // Status bit positions
  localparam int ST_RESET = 0;
  localparam int ST_MCHECK = 1;
  localparam int ST_SYNC = 2;
  localparam int ST_ASYNC = 3;
  localparam int ST_W = 4;
  // Exception classes
  typedef enum logic [2:0] {
    PES_CL_RESET, PES_CL_MCHECK, PES_CL_SYNC, PES_CL_TRAP, PES_CL_EXT,
    PES_CL_DEC, PES_CL_SMI
  } pes_class_t;
endpackage : pes_pkg

// File: pes_sequencer.sv
/*
  Precise exception sequencer of a superscalar core.
  Assumes the completion stage offers the oldest instruction's fault with
  its address and conditions, and reports when the store queue is empty.
*/
// Functional notes
// - Exceptions presented strictly in program order
// - Earlier instructions finish before instruction exception
// - Async precise waits completion and store drain
// - One exception at a time, except reset/check
// - Multiple conditions: lowest raised, rest reported in cause register
// - Save state, supervisor mode, fetch vector
// - Report fault address, block faulting and later
// - Trap/syscall resume at handler-supplied address
// - Imprecise FP modes handled as precise
// - Maskable interrupts wait next instruction completion
// - Idle pipeline: take once restart known
// - Reset/check non-maskable; recoverable flag reported
// - Finer cause register; conditions software enabled
// - Reset vectors to 00100 on either reset
// - Machine check vectors to 00200
// - External interrupt to 00500 when enable set
`timescale 1ns/10ps
`default_nettype none
module pes_sequencer
  import pes_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // System pins
  input wire logic hard_reset_in,
  input wire logic soft_reset_in,
  input wire logic transfer_error_ack_in,
  input wire logic data_bus_busy,
  input wire logic machine_check_in,
  input wire logic parity_error_in,
  input wire logic ext_irq_in,
  input wire logic decrementer_irq,
  input wire logic system_mgmt_irq,
  // Completion stage
  input wire logic cmpl_valid,
  input wire logic [31:0] cmpl_addr,
  input wire logic [31:0] cmpl_next_addr,
  input wire logic [7:0] cmpl_conds,
  input wire logic cmpl_is_trap,
  input wire logic cmpl_older_pending,
  input wire logic pipe_empty,
  input wire logic restart_known,
  input wire logic [31:0] restart_addr,
  input wire logic store_queue_empty,
  // Fetch redirect
  output logic redirect_valid,
  output logic [31:0] redirect_addr,
  output logic flush_younger,
  output logic supervisor_mode,
  output logic irq,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Architectural registers
  logic [31:0] machine_state_reg;   // Machine state
  logic [31:0] saved_restart_addr;  // Restart address save
  logic [31:0] saved_machine_state; // Machine state save
  logic [31:0] data_fault_cause;    // Finer cause
  logic [31:0] vector_taken;        // Last vector
  logic [31:0] resume_addr;         // Handler-supplied resume
  logic [7:0] cond_enable;          // Condition enables
  logic [31:0] ctrl;                // Control register
  logic [ST_W-1:0] status;          // Sticky events
  logic [ST_W-1:0] mask;            // Interrupt mask
  logic [7:0] cond_left;            // Conditions not yet raised
  logic in_handler;                 // One exception at a time
  logic [31:0] fp_status_control;   // FP control; mode bit only stored
  // Bus handshake state
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] rd_value;

  // Event decode
  logic any_reset, mcheck_ev, sync_ev, async_pend, take_async;
  logic [7:0] live_conds, first_cond;
  logic ext_pend;
  logic return_req;
  assign any_reset = hard_reset_in | soft_reset_in;
  assign mcheck_ev = machine_check_in | parity_error_in
                   | (transfer_error_ack_in & data_bus_busy);
  // Enabled conditions; FP ones stay precise whatever the mode bit
  assign live_conds = cmpl_conds & cond_enable;
  // Lowest condition bit raised, the rest kept in cond_left
  assign first_cond = live_conds & (~live_conds + 8'h01);
  assign sync_ev = cmpl_valid & !cmpl_older_pending
                 & (live_conds != 8'h00 || cmpl_is_trap);
  assign ext_pend = ext_irq_in & machine_state_reg[MS_EXT_EN];
  assign async_pend = ext_pend | (machine_state_reg[MS_EXT_EN]
                    & (decrementer_irq | system_mgmt_irq));
  // Boundary: completing instruction done or idle with restart known
  assign take_async = async_pend & store_queue_empty
                    & ((cmpl_valid & !cmpl_older_pending)
                       | (pipe_empty & restart_known));
  assign do_write = aw_held & w_held & !s_axi_bvalid;
  assign return_req = do_write && aw_addr == ADDR_CTRL && w_data[CTRL_RETURN];

  // Exception taking and state save
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      machine_state_reg <= MS_RESET;
      saved_restart_addr <= 32'h00000000;
      saved_machine_state <= 32'h00000000;
      data_fault_cause <= 32'h00000000;
      vector_taken <= VEC_RESERVED;
      redirect_valid <= 1'b0;
      redirect_addr <= VEC_RESET;
      flush_younger <= 1'b0;
      in_handler <= 1'b0;
      cond_left <= 8'h00;
    end else begin
      redirect_valid <= 1'b0;
      flush_younger <= 1'b0;
      if (any_reset) begin
        // Non-maskable, not recoverable
        saved_restart_addr <= cmpl_addr;
        saved_machine_state <= machine_state_reg;
        machine_state_reg <= MS_RESET;
        redirect_addr <= VEC_RESET;
        vector_taken <= VEC_RESET;
        redirect_valid <= 1'b1;
        flush_younger <= 1'b1;
        in_handler <= 1'b1;
      end else if (mcheck_ev) begin
        // Intervenes even inside a handler
        saved_restart_addr <= cmpl_addr;
        saved_machine_state <= machine_state_reg;
        machine_state_reg <= 32'h00000000;
        redirect_addr <= VEC_MCHECK;
        vector_taken <= VEC_MCHECK;
        redirect_valid <= 1'b1;
        flush_younger <= 1'b1;
        in_handler <= 1'b1;
      end else if (return_req) begin
        // Resume: restore state, fetch at handler address
        machine_state_reg <= saved_machine_state;
        redirect_addr <= resume_addr;
        redirect_valid <= 1'b1;
        in_handler <= 1'b0;
      end else if (!in_handler && sync_ev) begin
        // Fault address saved (next address on a trap), faulting and later blocked
        saved_restart_addr <= cmpl_is_trap ? cmpl_next_addr : cmpl_addr;
        saved_machine_state <= machine_state_reg;
        machine_state_reg <= {32{1'b0}} | (32'h1 << MS_RECOV);
        data_fault_cause <= {24'h000000, first_cond};
        cond_left <= live_conds & ~first_cond;
        redirect_addr <= cmpl_is_trap ? VEC_SYSCALL : VEC_PROGRAM;
        vector_taken <= cmpl_is_trap ? VEC_SYSCALL : VEC_PROGRAM;
        redirect_valid <= 1'b1;
        flush_younger <= 1'b1;
        in_handler <= 1'b1;
      end else if (!in_handler && take_async) begin
        // Precise async at a boundary
        saved_restart_addr <= pipe_empty ? restart_addr : cmpl_next_addr;
        saved_machine_state <= machine_state_reg;
        machine_state_reg <= 32'h1 << MS_RECOV;
        redirect_addr <= ext_pend ? VEC_EXT : (system_mgmt_irq ? VEC_SYS_MGMT : VEC_DEC);
        vector_taken <= ext_pend ? VEC_EXT : (system_mgmt_irq ? VEC_SYS_MGMT : VEC_DEC);
        redirect_valid <= 1'b1;
        flush_younger <= 1'b1;
        in_handler <= 1'b1;
      end else if (do_write && aw_addr == ADDR_MSTATE) begin
        machine_state_reg <= w_data;
      end
    end
  end

  assign supervisor_mode = !machine_state_reg[MS_USER];

  // Sticky status, set wins over write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= '0;
    end else begin
      for (int i = 0; i < ST_W; i++) begin
        if (do_write && aw_addr == ADDR_STATUS && w_data[i])
          status[i] <= 1'b0;
        if (i == ST_RESET && any_reset) status[i] <= 1'b1;
        if (i == ST_MCHECK && mcheck_ev) status[i] <= 1'b1;
        if (i == ST_SYNC && sync_ev && !in_handler) status[i] <= 1'b1;
        if (i == ST_ASYNC && take_async && !in_handler) status[i] <= 1'b1;
      end
    end
  end
  assign irq = |(status & mask);

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask <= '0;
      resume_addr <= 32'h00000000;
      cond_enable <= 8'hff;
      ctrl <= 32'h00000000;
      fp_status_control <= 32'h00000000;
    end else if (do_write) begin
      case (aw_addr)
        ADDR_MASK: mask <= w_data[ST_W-1:0];
        ADDR_RESUME: resume_addr <= w_data;
        ADDR_COND_EN: cond_enable <= w_data[7:0];
        ADDR_CTRL: begin
          ctrl <= w_data & 32'h00000002;
          fp_status_control[CTRL_FP_IMPRECISE] <= w_data[CTRL_FP_IMPRECISE];
        end
        default: ;
      endcase
    end
  end

  // Write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_bresp = 2'b00;

  // Read channel
  always_comb begin
    case (s_axi_araddr)
      ADDR_CTRL: rd_value = ctrl | fp_status_control;
      ADDR_MSTATE: rd_value = machine_state_reg;
      ADDR_SAVE_PC: rd_value = saved_restart_addr;
      ADDR_SAVE_MS: rd_value = saved_machine_state;
      ADDR_CAUSE: rd_value = data_fault_cause | {cond_left, 24'h000000};
      ADDR_STATUS: rd_value = {28'h0000000, status};
      ADDR_MASK: rd_value = {28'h0000000, mask};
      ADDR_VECTOR: rd_value = vector_taken;
      ADDR_RESUME: rd_value = resume_addr;
      ADDR_COND_EN: rd_value = {24'h000000, cond_enable};
      default: rd_value = 32'h00000000;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  // Assertions
  property p_reset_vec;
    @(posedge aclk) disable iff (!aresetn)
      any_reset |=> redirect_valid && redirect_addr == VEC_RESET;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
  property p_mcheck_vec;
    @(posedge aclk) disable iff (!aresetn)
      (mcheck_ev && !any_reset) |=> redirect_addr == VEC_MCHECK;
  endproperty
  a_mcheck_vec: assert property (p_mcheck_vec) else $error("mcheck vector wrong");
  property p_ext_vec;
    @(posedge aclk) disable iff (!aresetn)
      (take_async && ext_pend && !in_handler && !any_reset && !mcheck_ev && !return_req
       && !sync_ev) |=> redirect_addr == VEC_EXT;
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("ext vector wrong");
  property p_no_enable;
    @(posedge aclk) disable iff (!aresetn)
      !machine_state_reg[MS_EXT_EN] |-> !take_async;
  endproperty
  a_no_enable: assert property (p_no_enable) else $error("masked irq taken");
  property p_drain;
    @(posedge aclk) disable iff (!aresetn)
      !store_queue_empty |-> !take_async;
  endproperty
  a_drain: assert property (p_drain) else $error("store queue not drained");
  property p_order;
    @(posedge aclk) disable iff (!aresetn)
      cmpl_older_pending |-> !sync_ev;
  endproperty
  a_order: assert property (p_order) else $error("out of order exception");
  property p_one;
    @(posedge aclk) disable iff (!aresetn)
      (in_handler && !any_reset && !mcheck_ev && !return_req) |=> !redirect_valid;
  endproperty
  a_one: assert property (p_one) else $error("nested exception");
  property p_save;
    @(posedge aclk) disable iff (!aresetn)
      (sync_ev && !in_handler && !any_reset && !mcheck_ev && !return_req && !cmpl_is_trap)
      |=> saved_restart_addr == $past(cmpl_addr) && flush_younger;
  endproperty
  a_save: assert property (p_save) else $error("fault address not saved");
  property p_single_cause;
    @(posedge aclk) disable iff (!aresetn)
      $onehot0(data_fault_cause[7:0]);
  endproperty
  a_single_cause: assert property (p_single_cause) else $error("several causes");
endmodule : pes_sequencer
`default_nettype wire

// File: pes_sys_model.sv
/* System logic model: drives the reset, error and interrupt pins.
   Assumes the bench picks one event code and holds ev_on meanwhile. */
`timescale 1ns/10ps
`default_nettype none
module pes_sys_model (
  // Bench control
  input wire logic ev_on,
  input wire logic [2:0] ev_code,
  // System pins
  output logic hard_reset_in,
  output logic soft_reset_in,
  output logic machine_check_in,
  output logic parity_error_in,
  output logic transfer_error_ack_in,
  output logic data_bus_busy,
  output logic ext_irq_in,
  output logic decrementer_irq,
  output logic system_mgmt_irq
);
  // Each pin is a level that follows the selected event
  assign hard_reset_in = ev_on && ev_code == 3'h0;
  assign soft_reset_in = ev_on && ev_code == 3'h1;
  assign machine_check_in = ev_on && ev_code == 3'h2;
  assign parity_error_in = ev_on && ev_code == 3'h3;
  // Error acknowledge only inside a data bus tenure
  assign transfer_error_ack_in = ev_on && ev_code == 3'h4;
  assign data_bus_busy = ev_on && ev_code == 3'h4;
  // Maskable sources stay up until the bench drops them
  assign ext_irq_in = ev_on && ev_code == 3'h5;
  assign decrementer_irq = ev_on && ev_code == 3'h6;
  assign system_mgmt_irq = ev_on && ev_code == 3'h7;
endmodule : pes_sys_model
`default_nettype wire

// File: pes_sequencer_tb.sv
/* Self-checking bench of the exception sequencer.
   Assumes the system model beside it and an AXI4-Lite master in tasks. */
`timescale 1ns/10ps
`default_nettype none
module pes_sequencer_tb;
  import pes_pkg::*;
  // Clock, reset and model control
  logic aclk, aresetn, ev_on;
  logic [2:0] ev_code;
  // System pins
  logic hard_reset_in, soft_reset_in, transfer_error_ack_in, data_bus_busy;
  logic machine_check_in, parity_error_in, ext_irq_in, decrementer_irq, system_mgmt_irq;
  // Completion stage
  logic cmpl_valid, cmpl_is_trap, cmpl_older_pending, pipe_empty;
  logic restart_known, store_queue_empty;
  logic [31:0] cmpl_addr, cmpl_next_addr, restart_addr, d;
  logic [7:0] cmpl_conds;
  // Design outputs
  logic redirect_valid, flush_younger, supervisor_mode, irq;
  logic [31:0] redirect_addr;
  // AXI4-Lite
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_fail, n_checks, cyc;
  logic [31:0] vecs [3] = '{VEC_EXT, VEC_DEC, VEC_SYS_MGMT}; // Maskable vectors

  pes_sys_model sys (.ev_on(ev_on), .ev_code(ev_code), .hard_reset_in(hard_reset_in),
    .soft_reset_in(soft_reset_in), .machine_check_in(machine_check_in),
    .parity_error_in(parity_error_in), .transfer_error_ack_in(transfer_error_ack_in),
    .data_bus_busy(data_bus_busy), .ext_irq_in(ext_irq_in),
    .decrementer_irq(decrementer_irq), .system_mgmt_irq(system_mgmt_irq));

  pes_sequencer dut (.aclk(aclk), .aresetn(aresetn), .hard_reset_in(hard_reset_in),
    .soft_reset_in(soft_reset_in), .transfer_error_ack_in(transfer_error_ack_in),
    .data_bus_busy(data_bus_busy), .machine_check_in(machine_check_in),
    .parity_error_in(parity_error_in), .ext_irq_in(ext_irq_in),
    .decrementer_irq(decrementer_irq), .system_mgmt_irq(system_mgmt_irq),
    .cmpl_valid(cmpl_valid), .cmpl_addr(cmpl_addr), .cmpl_next_addr(cmpl_next_addr),
    .cmpl_conds(cmpl_conds), .cmpl_is_trap(cmpl_is_trap),
    .cmpl_older_pending(cmpl_older_pending), .pipe_empty(pipe_empty),
    .restart_known(restart_known), .restart_addr(restart_addr),
    .store_queue_empty(store_queue_empty), .redirect_valid(redirect_valid),
    .redirect_addr(redirect_addr), .flush_younger(flush_younger),
    .supervisor_mode(supervisor_mode), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Compare one value and count it
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Counts, verdict and end of run
  task final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end

  // AXI write: address and data offered together, released on their own handshake
  task axw(input logic [7:0] a, input logic [31:0] v);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        ta = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        tw = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axw

  // AXI read, data taken at the edge that sees rvalid
  task axr(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, 32'h0);
    s_axi_rready <= 1'b0;
  endtask : axr

  // Wait a bounded time for a redirect pulse
  task wait_redir(input int n, output logic f);
    f = 1'b0;
    repeat (n) if (!f) begin
      @(posedge aclk);
      if (redirect_valid === 1'b1) f = 1'b1;
    end
  endtask : wait_redir

  // Expect a redirect to a vector, flush as given
  task take(input logic [31:0] vec, input logic fl);
    logic f;
    wait_redir(20, f);
    chk({31'h0, f}, 32'h1);
    chk(redirect_addr, vec);
    chk({31'h0, flush_younger}, {31'h0, fl});
  endtask : take

  // Expect no redirect for a while
  task none_taken;
    logic f;
    wait_redir(6, f);
    chk({31'h0, f}, 32'h0);
  endtask : none_taken

  // Leave the handler through the control register
  task ret(input logic [31:0] v);
    axw(ADDR_CTRL, v);
    repeat (4) @(posedge aclk);
  endtask : ret

  // Main sequence
  initial begin
    {ev_on, ev_code, cmpl_valid, cmpl_is_trap, cmpl_older_pending, cmpl_conds} = '0;
    {cmpl_addr, cmpl_next_addr, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {pipe_empty, restart_known, store_queue_empty} = 3'h7;
    restart_addr = 32'h00003000;
    s_axi_wstrb = 4'hf;
    aresetn = 1'b0;
    n_fail = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(redirect_addr, VEC_RESET);
    axr(ADDR_MSTATE, d);
    chk(d, MS_RESET);
    axr(ADDR_COND_EN, d);
    chk(d, 32'h000000ff);
    axr(8'h3c, d);
    chk(d, 32'h0);
    // Both reset pins, then the three check sources
    for (int i = 0; i < 5; i++) begin
      @(posedge aclk);
      ev_code <= i[2:0];
      ev_on <= 1'b1;
      take((i < 2) ? VEC_RESET : VEC_MCHECK, 1'b1);
      ev_on <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    axr(ADDR_MSTATE, d);
    chk({31'h0, d[MS_RECOV]}, 32'h0);
    chk({31'h0, supervisor_mode}, 32'h1);
    // Still inside a handler: instruction fault must wait
    @(posedge aclk);
    cmpl_valid <= 1'b1;
    cmpl_conds <= 8'h01;
    none_taken();
    cmpl_valid <= 1'b0;
    ret(32'h3);
    // Fault held off while older work is unfinished
    @(posedge aclk);
    {cmpl_valid, cmpl_older_pending, cmpl_conds} <= {2'b11, 8'h06};
    cmpl_addr <= 32'h00001000;
    cmpl_next_addr <= 32'h00001004;
    none_taken();
    cmpl_older_pending <= 1'b0;
    take(VEC_PROGRAM, 1'b1);
    cmpl_valid <= 1'b0;
    axr(ADDR_SAVE_PC, d);
    chk(d, 32'h00001000);
    axr(ADDR_CAUSE, d);
    chk({24'h0, d[7:0]}, 32'h02);
    chk({24'h0, d[31:24]}, 32'h04);
    axr(ADDR_MSTATE, d);
    chk({31'h0, d[MS_RECOV]}, 32'h1);
    ret(32'h1);
    // Trap saves the next address; handler picks the resume point
    @(posedge aclk);
    {cmpl_valid, cmpl_is_trap, cmpl_conds} <= {2'b11, 8'h01};
    take(VEC_SYSCALL, 1'b1);
    {cmpl_valid, cmpl_is_trap} <= 2'b00;
    axr(ADDR_SAVE_PC, d);
    chk(d, 32'h00001004);
    axw(ADDR_RESUME, 32'h00002000);
    // Watch for the one-cycle pulse while the return write is under way
    fork
      axw(ADDR_CTRL, 32'h1);
      take(32'h00002000, 1'b0);
    join
    repeat (4) @(posedge aclk);
    // External line ignored while its enable is clear
    @(posedge aclk);
    ev_code <= 3'h5;
    ev_on <= 1'b1;
    none_taken();
    ev_on <= 1'b0;
    // Maskable sources on an idle pipeline
    for (int i = 0; i < 3; i++) begin
      axw(ADDR_MSTATE, 32'h00008000);
      @(posedge aclk);
      ev_code <= 3'h5 + i[2:0];
      ev_on <= 1'b1;
      if (i == 0) begin
        store_queue_empty <= 1'b0;
        none_taken();
        store_queue_empty <= 1'b1;
      end
      take(vecs[i], 1'b1);
      ev_on <= 1'b0;
      axr(ADDR_SAVE_PC, d);
      chk(d, 32'h00003000);
      axr(ADDR_SAVE_MS, d);
      chk(d, 32'h00008000);
      axr(ADDR_VECTOR, d);
      chk(d, vecs[i]);
      ret(32'h1);
    end
    // Status, mask and the interrupt output
    axw(ADDR_MASK, 32'h0);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axw(ADDR_MASK, 32'hf);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    axw(ADDR_STATUS, 32'hf);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    axr(ADDR_STATUS, d);
    chk(d, 32'h0);
    final_report();
  end
endmodule : pes_sequencer_tb
`default_nettype wire
